/* File: hdl/tld_pkg.sv */
// constants for the tone list decode register bank
package tld_pkg;
  // ----------------------------------------
  // command bytes
  // ----------------------------------------
  localparam logic [7:0] TLD_CMD_RESET   = 8'h01;
  localparam logic [7:0] TLD_CMD_CONTROL = 8'h30;
  localparam logic [7:0] TLD_CMD_AUX     = 8'h32;
  localparam logic [7:0] TLD_CMD_GSEL    = 8'h33;
  localparam logic [7:0] TLD_CMD_ENTRY   = 8'h34;
  localparam logic [7:0] TLD_CMD_LOC     = 8'h38;
  localparam logic [7:0] TLD_CMD_PARAMS  = 8'h3c;
  localparam logic [7:0] TLD_CMD_STATUS  = 8'h3f;
  // ----------------------------------------
  // fields
  // ----------------------------------------
  localparam int         TLD_CTRL_BANK   = 7;
  localparam int         TLD_CTRL_FAST   = 6;
  localparam logic [1:0] TLD_OP_ZERO     = 2'b00;
  localparam logic [1:0] TLD_OP_CLEAR    = 2'b01;
  localparam logic [1:0] TLD_OP_NORMAL   = 2'b10;
  localparam logic [1:0] TLD_MODE_OFF    = 2'b00;
  localparam logic [1:0] TLD_MODE_BOTH   = 2'b11;
  localparam logic [7:0] TLD_GSEL_MASK   = 8'hc0;
  localparam int         TLD_ST_TCHG     = 5;
  localparam int         TLD_ST_FULL     = 4;
  localparam int         TLD_ST_SCHG     = 3;
  localparam int         TLD_ST_DEC      = 2;
  localparam int         TLD_ST_UNL      = 1;
  localparam int         TLD_ST_BANK     = 0;
  localparam logic [7:0] TLD_REG_RESET   = 8'h00;
  // ----------------------------------------
  // list geometry
  // ----------------------------------------
  localparam int         TLD_DEPTH       = 32;
  localparam int         TLD_PTR_W       = 5;
  localparam int         TLD_NR_W        = 14;
  localparam logic [5:0] TLD_FULL_COUNT  = 6'h20;
  localparam logic [4:0] TLD_LAST_LOC    = 5'h1f;
  localparam logic [1:0] TLD_BYTE_CMD    = 2'h0;
  localparam logic [1:0] TLD_BYTE_HI     = 2'h1;
  localparam logic [1:0] TLD_BYTE_LO     = 2'h2;
  typedef enum logic [1:0] {TLD_NOTONE, TLD_LISTED, TLD_UNLISTED} tld_dec_e;
  typedef enum logic {TLD_IDLE, TLD_RUN} tld_srch_e;
endpackage

/* File: hdl/tld_serial_port.sv */
// chip-select framed serial byte port, msb first
`timescale 1ns/1ps
`default_nettype none
module tld_serial_port (
  input  wire logic       ref_clk,
  input  wire logic       rst,
  input  wire logic       chip_select_low,
  input  wire logic       serial_clock,
  input  wire logic       command_data,
  input  wire logic       tx_load,
  input  wire logic [7:0] tx_byte,
  output logic      [7:0] rx_byte,
  output logic            rx_valid,
  output logic            reply_data,
  output logic            reply_data_oe
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  logic       sclk_q, next_sclk_q;
  logic [2:0] cnt, next_cnt;
  logic [7:0] sr, next_sr, txsr, next_txsr;
  logic [7:0] next_rx_byte;
  logic       next_rx_valid, next_reply, next_oe, skip, next_skip;
  logic       rise, fall;

  always_comb begin
    rise          = serial_clock & ~sclk_q;
    fall          = ~serial_clock & sclk_q;
    next_sclk_q   = serial_clock;
    next_cnt      = cnt;
    next_sr       = sr;
    next_txsr     = txsr;
    next_rx_byte  = rx_byte;
    next_rx_valid = 1'b0;
    next_reply    = reply_data;
    next_oe       = reply_data_oe;
    next_skip     = skip;
    if (chip_select_low) begin
      next_cnt  = 3'h0;
      next_oe   = 1'b0;
      next_skip = 1'b0;
    end else begin
      if (rise) begin
        next_sr  = {sr[6:0], command_data};
        next_cnt = cnt + 3'h1;
        if (cnt == 3'h7) begin
          next_rx_byte  = {sr[6:0], command_data};
          next_rx_valid = 1'b1;
        end
      end
      // the fall closing the byte just taken must not shift the reply
      if (fall) begin
        if (skip) begin
          next_skip = 1'b0;
        end else begin
          next_txsr  = {txsr[6:0], 1'b0};
          next_reply = txsr[6];
        end
      end
      if (tx_load) begin
        next_txsr  = tx_byte;
        next_reply = tx_byte[7];
        next_oe    = 1'b1;
        next_skip  = 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sclk_q        <= 1'b0;
      cnt           <= 3'h0;
      sr            <= 8'h00;
      txsr          <= 8'h00;
      rx_byte       <= 8'h00;
      rx_valid      <= 1'b0;
      reply_data    <= 1'b0;
      reply_data_oe <= 1'b0;
      skip          <= 1'b0;
    end else begin
      sclk_q        <= next_sclk_q;
      cnt           <= next_cnt;
      sr            <= next_sr;
      txsr          <= next_txsr;
      rx_byte       <= next_rx_byte;
      rx_valid      <= next_rx_valid;
      reply_data    <= next_reply;
      reply_data_oe <= next_oe;
      skip          <= next_skip;
    end
  end
endmodule
`default_nettype wire

/* File: hdl/tld_tone_list_registers.sv */
// tone list registers, list storage, list search and decode status
// Contract
// - decode mode 00 disables tone interrupt and forces the no-tone state.
// - mode 01 searches second-group entries, 10 first-group; interrupt enabled.
// - listed tone outside the selected group is ignored.
// - each entry write appends to selected list; last 32 kept.
// - clear zeroes every frequency field of the selected list; zero frequency means unused location.
// - entry bits 15..14 give group: none, second, first, both.
// - match interrupt only with active mode and entry group including it.
// - entry frequency is coarse bits 13..7 and fine bits 6..0.
// - location register shows matched location in bits 4..0, upper zero.
// - location 0 is the oldest kept entry, 31 the last location.
// - location and decoded parameters update in the same cycle.
// - different listed tone while listed-decoded sets tone-change flag bit 5.
// - list-full flag bit 4 sets when 32 entries are loaded.
// - zero-power mode leaves list-full flag and lists unchanged.
// - clear or reset command zeroes list-full; reset command keeps lists.
// - tone loss while listed-decoded or parameter change sets status-change bit 3.
// - interrupt pin low on status-change, tone-change or list-full rise.
// - status read releases interrupt, clears status-change and tone-change.
// - mode 00 also zeroes bank, unlisted, decode, status and tone flags.
`timescale 1ns/1ps
`default_nettype none
module tld_tone_list_registers (
  input  wire logic                         ref_clk,
  input  wire logic                         rst,
  input  wire logic                         chip_select_low,
  input  wire logic                         serial_clock,
  input  wire logic                         command_data,
  input  wire logic                         tone_detect,
  input  wire logic [tld_pkg::TLD_NR_W-1:0] tone_measured,
  input  wire logic [tld_pkg::TLD_NR_W-1:0] match_window,
  input  wire logic                         tone_lost,
  output logic                              reply_data,
  output logic                              reply_data_oe,
  output logic                              interrupt_out_low,
  output logic                              fast_mode,
  output logic                              input_hold
);
  import tld_pkg::*;

  // ----------------------------------------
  // serial byte port
  // ----------------------------------------
  logic [7:0] rx_byte;
  logic       rx_valid;
  logic       tx_load;
  logic [7:0] tx_byte;

  tld_serial_port u_port (
    .ref_clk         (ref_clk),
    .rst             (rst),
    .chip_select_low (chip_select_low),
    .serial_clock    (serial_clock),
    .command_data    (command_data),
    .tx_load         (tx_load),
    .tx_byte         (tx_byte),
    .rx_byte         (rx_byte),
    .rx_valid        (rx_valid),
    .reply_data      (reply_data),
    .reply_data_oe   (reply_data_oe)
  );

  // ----------------------------------------
  // register and list state
  // ----------------------------------------
  logic [15:0]          mem [2][TLD_DEPTH];
  logic [7:0]           ctrl, next_ctrl, gsel, next_gsel;
  logic [7:0]           cmd, next_cmd, hi_byte, next_hi_byte;
  logic [1:0]           byte_idx, next_byte_idx;
  logic [TLD_PTR_W-1:0] wp [2];
  logic [TLD_PTR_W-1:0] next_wp [2];
  logic [5:0]           cnt [2];
  logic [5:0]           next_cnt [2];
  logic                 next_input_hold, wr_go, clr_go, reset_go, status_rd;
  logic [15:0]          wr_data;
  logic                 bank;
  logic [1:0]           mode;

  // decode state
  tld_dec_e             dec, next_dec;
  tld_srch_e            srch, next_srch;
  logic [TLD_PTR_W-1:0] sidx, next_sidx;
  logic [TLD_NR_W-1:0]  snr, next_snr;
  logic                 s_other, next_s_other;
  logic [15:0]          params, next_params;
  logic [4:0]           loc, next_loc;
  logic                 bank_hit, next_bank_hit;
  logic                 tchg, next_tchg, schg, next_schg;
  logic                 full, next_full, full_pend, next_full_pend;
  logic                 next_irq_n;
  logic [7:0]           status_val;
  logic [TLD_PTR_W-1:0] phys, base;
  logic [15:0]          entry;
  logic [TLD_NR_W-1:0]  diff;
  logic                 near, hit, last;

  assign bank = ctrl[TLD_CTRL_BANK];
  assign mode = gsel[7:6];

  // ----------------------------------------
  // command handling
  // ----------------------------------------
  always_comb begin
    next_ctrl       = ctrl;
    next_gsel       = gsel;
    next_cmd        = cmd;
    next_hi_byte    = hi_byte;
    next_byte_idx   = byte_idx;
    next_input_hold = input_hold;
    next_wp         = wp;
    next_cnt        = cnt;
    wr_go           = 1'b0;
    clr_go          = 1'b0;
    reset_go        = 1'b0;
    status_rd       = 1'b0;
    tx_load         = 1'b0;
    tx_byte         = 8'h00;
    wr_data         = {hi_byte, rx_byte};
    if (chip_select_low) begin
      next_byte_idx = TLD_BYTE_CMD;
    end else if (rx_valid) begin
      if (byte_idx != TLD_BYTE_LO) begin
        next_byte_idx = byte_idx + 2'h1;
      end
      if (byte_idx == TLD_BYTE_CMD) begin
        next_cmd = rx_byte;
        unique case (rx_byte)
          TLD_CMD_RESET: begin
            reset_go        = 1'b1;
            next_ctrl       = TLD_REG_RESET;
            next_gsel       = TLD_REG_RESET;
            next_input_hold = 1'b0;
          end
          TLD_CMD_LOC: begin
            tx_load = 1'b1;
            tx_byte = {3'h0, loc};
          end
          TLD_CMD_PARAMS: begin
            tx_load = 1'b1;
            tx_byte = params[15:8];
          end
          TLD_CMD_STATUS: begin
            tx_load   = 1'b1;
            tx_byte   = status_val;
            status_rd = 1'b1;
          end
          default: ;
        endcase
      end else if (byte_idx == TLD_BYTE_HI) begin
        next_hi_byte = rx_byte;
        unique case (cmd)
          TLD_CMD_CONTROL: begin
            next_ctrl = rx_byte;
            if (rx_byte[1:0] == TLD_OP_CLEAR) begin
              clr_go         = 1'b1;
              next_wp[bank]  = '0;
              next_cnt[bank] = 6'h00;
            end
          end
          TLD_CMD_AUX:    next_input_hold = rx_byte[0];
          // reserved bits are dropped even if the host sets them
          TLD_CMD_GSEL:   next_gsel = rx_byte & TLD_GSEL_MASK;
          TLD_CMD_PARAMS: begin
            tx_load = 1'b1;
            tx_byte = params[7:0];
          end
          default: ;
        endcase
      end else if (cmd == TLD_CMD_ENTRY) begin
        wr_go         = 1'b1;
        next_wp[bank] = wp[bank] + 5'h01;
        if (cnt[bank] != TLD_FULL_COUNT) begin
          next_cnt[bank] = cnt[bank] + 6'h01;
        end
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ctrl       <= TLD_REG_RESET;
      gsel       <= TLD_REG_RESET;
      cmd        <= 8'h00;
      hi_byte    <= 8'h00;
      byte_idx   <= TLD_BYTE_CMD;
      input_hold <= 1'b0;
      fast_mode  <= 1'b0;
      wp[0]      <= '0;
      wp[1]      <= '0;
      cnt[0]     <= 6'h00;
      cnt[1]     <= 6'h00;
    end else begin
      ctrl       <= next_ctrl;
      gsel       <= next_gsel;
      cmd        <= next_cmd;
      hi_byte    <= next_hi_byte;
      byte_idx   <= next_byte_idx;
      input_hold <= next_input_hold;
      fast_mode  <= next_ctrl[TLD_CTRL_FAST];
      wp         <= next_wp;
      cnt        <= next_cnt;
    end
  end

  // ----------------------------------------
  // list storage
  // ----------------------------------------
  // no reset, so lists survive reset command and zero power
  always_ff @(posedge ref_clk) begin
    if (clr_go) begin
      for (int i = 0; i < TLD_DEPTH; i++) begin
        mem[bank][i][TLD_NR_W-1:0] <= '0;
      end
    end else if (wr_go) begin
      mem[bank][wp[bank]] <= wr_data;
    end
  end

  // ----------------------------------------
  // list search and decode status
  // ----------------------------------------
  always_comb begin
    // location 0 is the oldest entry
    base  = (cnt[bank] == TLD_FULL_COUNT) ? wp[bank] : '0;
    phys  = base + sidx;
    entry = mem[bank][phys];
    diff  = (snr >= entry[TLD_NR_W-1:0]) ? snr - entry[TLD_NR_W-1:0]
                                          : entry[TLD_NR_W-1:0] - snr;
    // zero frequency marks an unused location
    near  = (entry[TLD_NR_W-1:0] != '0) && (diff <= match_window);
    hit   = near && ((entry[15:14] & mode) != 2'b00);
    last  = (sidx == TLD_LAST_LOC);
    status_val = 8'h00;
    status_val[TLD_ST_TCHG] = tchg;
    status_val[TLD_ST_FULL] = full;
    status_val[TLD_ST_SCHG] = schg;
    status_val[TLD_ST_DEC]  = (dec != TLD_NOTONE);
    status_val[TLD_ST_UNL]  = (dec == TLD_UNLISTED);
    status_val[TLD_ST_BANK] = bank_hit;
    if (ctrl[1:0] == TLD_OP_ZERO) begin
      status_val = 8'h00;
      status_val[TLD_ST_FULL] = full;
    end
    next_dec       = dec;
    next_srch      = srch;
    next_sidx      = sidx;
    next_snr       = snr;
    next_s_other   = s_other;
    next_params    = params;
    next_loc       = loc;
    next_bank_hit  = bank_hit;
    next_tchg      = tchg;
    next_schg      = schg;
    next_full      = full;
    next_full_pend = full_pend;
    if (status_rd) begin
      next_tchg      = 1'b0;
      next_schg      = 1'b0;
      next_full_pend = 1'b0;
    end
    if (clr_go || reset_go) begin
      next_full = 1'b0;
    end
    if (wr_go && (next_cnt[bank] == TLD_FULL_COUNT) && !full) begin
      next_full      = 1'b1;
      next_full_pend = 1'b1;
    end
    if (srch == TLD_IDLE) begin
      if (tone_detect && (mode != TLD_MODE_OFF) && (mode != TLD_MODE_BOTH)
          && (ctrl[1:0] == TLD_OP_NORMAL)) begin
        next_srch    = TLD_RUN;
        next_sidx    = '0;
        next_snr     = tone_measured;
        next_s_other = 1'b0;
      end
    end else begin
      next_sidx = sidx + 5'h01;
      if (near && !hit) begin
        next_s_other = 1'b1;
      end
      if (hit || last) begin
        next_srch = TLD_IDLE;
      end
      if (hit) begin
        if ((dec != TLD_LISTED) || (entry != params)) begin
          if (dec == TLD_LISTED) begin
            next_tchg = 1'b1;
          end
          next_schg = 1'b1;
        end
        next_params   = entry;
        next_loc      = sidx;
        next_bank_hit = bank;
        next_dec      = TLD_LISTED;
      end else if (last && !near && !s_other) begin
        next_dec = TLD_UNLISTED;
      end
    end
    if (tone_lost && (dec != TLD_NOTONE)) begin
      if (dec == TLD_LISTED) begin
        next_schg = 1'b1;
      end
      next_dec = TLD_NOTONE;
    end
    if (mode == TLD_MODE_OFF) begin
      next_srch     = TLD_IDLE;
      next_dec      = TLD_NOTONE;
      next_tchg     = 1'b0;
      next_schg     = 1'b0;
      next_bank_hit = 1'b0;
    end
    if (reset_go) begin
      next_params = 16'h0000;
      next_loc    = 5'h00;
    end
    next_irq_n = ~(next_schg | next_tchg | next_full_pend);
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      dec               <= TLD_NOTONE;
      srch              <= TLD_IDLE;
      sidx              <= '0;
      snr               <= '0;
      s_other           <= 1'b0;
      params            <= 16'h0000;
      loc               <= 5'h00;
      bank_hit          <= 1'b0;
      tchg              <= 1'b0;
      schg              <= 1'b0;
      full              <= 1'b0;
      full_pend         <= 1'b0;
      interrupt_out_low <= 1'b1;
    end else begin
      dec               <= next_dec;
      srch              <= next_srch;
      sidx              <= next_sidx;
      snr               <= next_snr;
      s_other           <= next_s_other;
      params            <= next_params;
      loc               <= next_loc;
      bank_hit          <= next_bank_hit;
      tchg              <= next_tchg;
      schg              <= next_schg;
      full              <= next_full;
      full_pend         <= next_full_pend;
      interrupt_out_low <= next_irq_n;
    end
  end
endmodule
`default_nettype wire

/* File: tb/tld_host_model.sv */
// host side of the chip-select framed serial port
`timescale 1ns/1ps
`default_nettype none
module tld_host_model (
  input  wire logic ref_clk,
  input  wire logic reply_data,
  output var logic  chip_select_low,
  output var logic  serial_clock,
  output var logic  command_data
);
  // half serial period in ref_clk cycles; 4 is the fastest the port takes
  int half = 4;
  initial begin
    chip_select_low = 1'b1;
    serial_clock    = 1'b0;
    command_data    = 1'b0;
  end
  // frame: select low, command, data bytes msb first, select high
  task automatic xfer(input logic [7:0] cmd, input logic [15:0] wr, input int nwr,
                      input int nrd, output logic [15:0] rd);
    logic [7:0] b;
    rd = 16'h0000;
    @(posedge ref_clk) #1;
    chip_select_low = 1'b0;
    for (int k = 0; k < 1 + nwr + nrd; k++) begin
      b = (k == 0) ? cmd : (k == 1) ? wr[15:8] : wr[7:0];
      for (int i = 7; i >= 0; i--) begin
        // unused data line toggles so nothing can lean on a stale level
        command_data = (k > nwr) ? ~command_data : b[i];
        repeat (half) @(posedge ref_clk);
        #1;
        if (k > nwr) rd = {rd[14:0], reply_data};
        serial_clock = 1'b1;
        repeat (half) @(posedge ref_clk);
        #1;
        serial_clock = 1'b0;
      end
    end
    repeat (half) @(posedge ref_clk);
    #1;
    chip_select_low = 1'b1;
    repeat (2 * half) @(posedge ref_clk);
    #1;
  endtask
endmodule
`default_nettype wire

/* File: tb/tld_tone_list_registers_sva.sv */
// port-level checker for the tone list register bank
`timescale 1ns/1ps
`default_nettype none
module tld_tone_list_registers_sva (
  input wire logic                         ref_clk,
  input wire logic                         rst,
  input wire logic                         chip_select_low,
  input wire logic                         serial_clock,
  input wire logic                         command_data,
  input wire logic                         tone_detect,
  input wire logic [tld_pkg::TLD_NR_W-1:0] tone_measured,
  input wire logic [tld_pkg::TLD_NR_W-1:0] match_window,
  input wire logic                         tone_lost,
  input wire logic                         reply_data,
  input wire logic                         reply_data_oe,
  input wire logic                         interrupt_out_low,
  input wire logic                         fast_mode,
  input wire logic                         input_hold
);
  import tld_pkg::*;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  // cycles with no frame and no detector event; a search never outlasts 40
  logic [5:0] quiet;
  logic [5:0] next_quiet;
  always_comb begin
    next_quiet = quiet;
    if (!chip_select_low || tone_detect || tone_lost) next_quiet = 6'h00;
    else if (quiet != 6'h3f) next_quiet = quiet + 6'h01;
  end
  always_ff @(posedge ref_clk) begin
    if (rst) quiet <= 6'h00;
    else quiet <= next_quiet;
  end
  sequence reset_idle;
    (interrupt_out_low && !reply_data_oe && !fast_mode && !input_hold) [*4];
  endsequence
  sequence frame_end;
    $rose(chip_select_low);
  endsequence
  reset_clean_a: assert property ($fell(rst) |-> reset_idle)
    else $error("outputs not idle after reset");
  oe_release_a: assert property (frame_end |-> ##[1:3] !reply_data_oe)
    else $error("reply driver kept after frame end");
  oe_late_a: assert property ($rose(reply_data_oe) |->
    !chip_select_low && $past(!chip_select_low, 60))
    else $error("reply driver enabled before a command byte");
  reply_frame_a: assert property ($changed(reply_data) |->
    reply_data_oe || $past(reply_data_oe))
    else $error("reply bit moved outside a read");
  fast_frame_a: assert property ($changed(fast_mode) |->
    $past(!chip_select_low) || $past(rst))
    else $error("fast mode changed outside a frame");
  hold_frame_a: assert property ($changed(input_hold) |->
    $past(!chip_select_low) || $past(rst))
    else $error("input hold changed outside a frame");
  irq_release_a: assert property ($rose(interrupt_out_low) |->
    $past(!chip_select_low) || $past(rst))
    else $error("interrupt released without a frame");
  irq_quiet_a: assert property ($fell(interrupt_out_low) |-> quiet < 6'h28)
    else $error("interrupt raised with no cause");
endmodule
`default_nettype wire

/* File: tb/tld_tone_list_registers_tb_top.sv */
// self-checking bench for the tone list register bank
`timescale 1ns/1ps
`default_nettype none
module tld_tone_list_registers_tb_top;
  import tld_pkg::*;
  logic                ref_clk;
  logic                rst;
  logic                chip_select_low;
  logic                serial_clock;
  logic                command_data;
  logic                tone_detect;
  logic                tone_lost;
  logic [TLD_NR_W-1:0] tone_measured;
  logic                reply_data;
  logic                reply_data_oe;
  logic                interrupt_out_low;
  logic                fast_mode;
  logic                input_hold;
  logic [15:0]         rd;
  int                  err_count = 0;
  int                  checks = 0;
  tld_host_model i_host (.ref_clk(ref_clk), .reply_data(reply_data),
    .chip_select_low(chip_select_low), .serial_clock(serial_clock),
    .command_data(command_data));
  tld_tone_list_registers i_dut (.ref_clk(ref_clk), .rst(rst),
    .chip_select_low(chip_select_low), .serial_clock(serial_clock),
    .command_data(command_data), .tone_detect(tone_detect), .tone_measured(tone_measured),
    .match_window(14'h0008), .tone_lost(tone_lost), .reply_data(reply_data),
    .reply_data_oe(reply_data_oe), .interrupt_out_low(interrupt_out_low),
    .fast_mode(fast_mode), .input_hold(input_hold));
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] cmd, input logic [15:0] d, input int n);
    i_host.xfer(cmd, d, n, 0, rd);
  endtask
  task automatic rd_reg(input logic [7:0] cmd, input int n, input logic [15:0] exp,
                        input string what);
    i_host.xfer(cmd, 16'h0000, 0, n, rd);
    check(what, rd, exp);
  endtask
  // groups cycle second, first, both; coarse count k+2, fine 0
  function automatic logic [15:0] entry(input int k);
    logic [1:0] g;
    g = (k % 3 == 0) ? 2'b01 : (k % 3 == 1) ? 2'b10 : 2'b11;
    return {g, 7'(k + 2), 7'h00};
  endfunction
  // negative k asks for a tone near zero frequency
  task automatic tone(input int k);
    logic [15:0] e;
    e = entry(k);
    @(posedge ref_clk) #1;
    tone_measured = ((k < 0) ? 14'h0000 : e[13:0]) + 14'h0003;
    tone_detect = 1'b1;
    @(posedge ref_clk) #1;
    tone_detect = 1'b0;
    repeat (40) @(posedge ref_clk);
    #1;
  endtask
  task automatic give_verdict;
    $display("checks %0d err_count %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // ----------------------------------------
  // stimulus
  // ----------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  initial begin
    #500_000;
    err_count++;
    give_verdict();
  end
  initial begin
    rst = 1'b1;
    tone_detect = 1'b0;
    tone_lost = 1'b0;
    tone_measured = 14'h0000;
    repeat (6) @(posedge ref_clk);
    #1;
    rst = 1'b0;
    rd_reg(TLD_CMD_STATUS, 1, 16'h0000, "status");
    // clear before loading, hold input during the load
    wr(TLD_CMD_CONTROL, 16'h4100, 1);
    wr(TLD_CMD_CONTROL, 16'h4200, 1);
    wr(TLD_CMD_AUX, 16'h0100, 1);
    check("fast", fast_mode, 1'b1);
    check("hold", input_hold, 1'b1);
    for (int k = 0; k < 33; k++) begin
      wr(TLD_CMD_ENTRY, entry(k), 2);
      if (k == 30) check("irq", interrupt_out_low, 1'b1);
      if (k == 31) check("irq", interrupt_out_low, 1'b0);
    end
    rd_reg(TLD_CMD_STATUS, 1, 16'h0010, "status");
    check("irq", interrupt_out_low, 1'b1);
    wr(TLD_CMD_AUX, 16'h0000, 1);
    check("hold", input_hold, 1'b0);
    // only legal decode modes, reserved bits zero
    wr(TLD_CMD_GSEL, 16'h8000, 1);
    tone(4);
    check("irq", interrupt_out_low, 1'b0);
    rd_reg(TLD_CMD_LOC, 1, 16'h0003, "location");
    rd_reg(TLD_CMD_PARAMS, 2, entry(4), "params");
    rd_reg(TLD_CMD_STATUS, 1, 16'h001c, "status");
    check("irq", interrupt_out_low, 1'b1);
    tone(6);
    check("irq", interrupt_out_low, 1'b1);
    rd_reg(TLD_CMD_STATUS, 1, 16'h0014, "status");
    tone(5);
    rd_reg(TLD_CMD_STATUS, 1, 16'h003c, "status");
    rd_reg(TLD_CMD_LOC, 1, 16'h0004, "location");
    wr(TLD_CMD_GSEL, 16'h4000, 1);
    tone(6);
    check("irq", interrupt_out_low, 1'b0);
    rd_reg(TLD_CMD_PARAMS, 2, entry(6), "params");
    rd_reg(TLD_CMD_STATUS, 1, 16'h003c, "status");
    @(posedge ref_clk) #1;
    tone_lost = 1'b1;
    @(posedge ref_clk) #1;
    tone_lost = 1'b0;
    repeat (4) @(posedge ref_clk);
    #1;
    check("irq", interrupt_out_low, 1'b0);
    rd_reg(TLD_CMD_STATUS, 1, 16'h0018, "status");
    // a slower host from here on
    i_host.half = 9;
    wr(TLD_CMD_GSEL, 16'h0000, 1);
    tone(4);
    check("irq", interrupt_out_low, 1'b1);
    rd_reg(TLD_CMD_STATUS, 1, 16'h0010, "status");
    wr(TLD_CMD_CONTROL, 16'h4000, 1);
    rd_reg(TLD_CMD_STATUS, 1, 16'h0010, "status");
    wr(TLD_CMD_CONTROL, 16'h4100, 1);
    wr(TLD_CMD_CONTROL, 16'h4200, 1);
    rd_reg(TLD_CMD_STATUS, 1, 16'h0000, "status");
    wr(TLD_CMD_ENTRY, entry(7), 2);
    wr(TLD_CMD_GSEL, 16'h8000, 1);
    tone(7);
    rd_reg(TLD_CMD_LOC, 1, 16'h0000, "location");
    rd_reg(TLD_CMD_STATUS, 1, 16'h000c, "status");
    tone(-1);
    check("irq", interrupt_out_low, 1'b1);
    i_host.xfer(TLD_CMD_STATUS, 16'h0000, 0, 1, rd);
    check("unlisted", 16'(rd[1]), 16'h0001);
    wr(TLD_CMD_RESET, 16'h0000, 0);
    check("fast", fast_mode, 1'b0);
    rd_reg(TLD_CMD_STATUS, 1, 16'h0000, "status");
    give_verdict();
  end
endmodule
bind tld_tone_list_registers tld_tone_list_registers_sva i_sva (.ref_clk(ref_clk), .rst(rst),
  .chip_select_low(chip_select_low), .serial_clock(serial_clock),
  .command_data(command_data), .tone_detect(tone_detect), .tone_measured(tone_measured),
  .match_window(match_window), .tone_lost(tone_lost), .reply_data(reply_data),
  .reply_data_oe(reply_data_oe), .interrupt_out_low(interrupt_out_low),
  .fast_mode(fast_mode), .input_hold(input_hold));
`default_nettype wire
